// *** logic/ptc_defines.svh ***
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH
// ============================================================
// Register byte offsets
`define PTC_OFF_WIN4 8'h9C
`define PTC_OFF_CTL 8'hA0
`define PTC_OFF_DATA 8'hA4
`define PTC_OFF_STS 8'hA8
// ============================================================
// Window-4 setup fields and fixed values
`define PTC_WIN4_SPACE_BIT 0
`define PTC_WIN4_SPACE_VAL 1'h0
`define PTC_WIN4_TYPE_HI 2
`define PTC_WIN4_TYPE_LO 1
`define PTC_WIN4_TYPE_VAL 2'h0
`define PTC_WIN4_CACHE_BIT 3
`define PTC_WIN4_CACHE_VAL 1'h0
`define PTC_WIN4_SIZE_HI 9
`define PTC_WIN4_SIZE_LO 4
`define PTC_WIN4_SIZE_VAL 6'hC
`define PTC_WIN4_EN_BIT 31
`define PTC_WIN4_EN_LANE 3
// ============================================================
// Control register fields
`define PTC_CTL_DW_HI 7
`define PTC_CTL_DW_LO 2
`define PTC_CTL_UP_HI 11
`define PTC_CTL_UP_LO 8
`define PTC_CTL_FN_HI 14
`define PTC_CTL_FN_LO 12
`define PTC_CTL_SLOT_HI 19
`define PTC_CTL_SLOT_LO 15
`define PTC_CTL_BUS_HI 27
`define PTC_CTL_BUS_LO 20
`define PTC_CTL_KIND_BIT 30
`define PTC_CTL_RW_BIT 31
`define PTC_CTL_WMASK 32'hCFFF_FFFC
`define PTC_CTL_STICKY 32'h8FFF_FFFC
// ============================================================
// Status register fields, completion codes, bus answers
`define PTC_STS_BUSY_BIT 0
`define PTC_STS_DONE_BIT 1
`define PTC_STS_CODE_HI 4
`define PTC_STS_CODE_LO 2
`define PTC_STS_ABORT_BIT 5
`define PTC_STS_CAP_BIT 31
`define PTC_CPL_SC 3'h0
`define PTC_CPL_UR 3'h1
`define PTC_CPL_CRS 3'h2
`define PTC_CPL_CA 3'h3
`define PTC_CPL_RA 3'h4
`define PTC_RESP_OKAY 2'h0
`define PTC_RESP_SLVERR 2'h2
`endif

// *** logic/ptc_pkg.sv ***
`default_nettype none
package ptc_pkg;

  // ============================================================
  // Launcher states, Gray coded along idle, request, wait.
  typedef enum logic [1:0]
  {
    LCH_IDLE = 2'h0,
    LCH_REQ  = 2'h1,
    LCH_WAIT = 2'h3
  } ptc_lch_e;

  // Configuration request sent to the far side of the bridge.
  typedef struct packed {
    logic        write;
    logic        kind;
    logic [3:0]  be;
    logic [7:0]  bus;
    logic [4:0]  slot;
    logic [2:0]  fn;
    logic [3:0]  upper;
    logic [5:0]  dword;
    logic [31:0] data;
  } ptc_cfg_req_s;

  // Completion returned by the far side.
  typedef struct packed {
    logic [2:0]  status;
    logic [31:0] data;
  } ptc_cpl_s;

  // Whole state of the launcher.
  typedef struct packed {
    ptc_lch_e     st;
    logic         busy;
    logic         req_valid;
    logic         cancel;
    ptc_cfg_req_s req;
  } ptc_lch_s;

endpackage
`default_nettype wire

// *** logic/ptc_lane_merge.sv ***
`default_nettype none
// ============================================================
// Byte-lane write merge
module ptc_lane_merge
#(
  parameter int LANES = 4
)(
  input  wire logic [8*LANES-1:0] old_word,
  input  wire logic [8*LANES-1:0] new_word,
  input  wire logic [LANES-1:0]   strb,
  input  wire logic [8*LANES-1:0] wmask,
  output logic      [8*LANES-1:0] merged
);

  if (LANES < 1)
  begin : g_chk
    $error("ptc_lane_merge needs at least one lane.");
  end

  // Only strobed lanes change, and only their writable bits.
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    assign merged[8*i +: 8] = strb[i] ?
      ((new_word[8*i +: 8] & wmask[8*i +: 8]) |
       (old_word[8*i +: 8] & ~wmask[8*i +: 8])) :
      old_word[8*i +: 8];
  end

endmodule
`default_nettype wire

// *** logic/ptc_launcher.sv ***
`default_nettype none
// ============================================================
// Configuration transaction launcher
module ptc_launcher
  import ptc_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          rst_n,
  input  wire logic          launch,
  input  wire ptc_cfg_req_s  launch_req,
  input  wire logic          abort,
  output var  ptc_cfg_req_s  req,
  output logic               req_valid,
  input  wire logic          req_ready,
  input  wire logic          cpl_valid,
  output logic               cancel,
  output logic               busy,
  output logic               fin
);

  ptc_lch_s st_r;
  ptc_lch_s st_nxt;

  // Next state; a completion in the same cycle as an abort wins.
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.cancel = 1'b0;
    fin           = 1'b0;
    case (st_r.st)
      LCH_IDLE:
        if (launch)
        begin
          st_nxt.st        = LCH_REQ;
          st_nxt.req       = launch_req;
          st_nxt.req_valid = 1'b1;
          st_nxt.busy      = 1'b1;
        end
      LCH_REQ:
        if (abort)
        begin
          st_nxt           = '0;
          st_nxt.req       = st_r.req;
          st_nxt.cancel    = 1'b1;
        end
        else if (req_ready)
        begin
          st_nxt.st        = LCH_WAIT;
          st_nxt.req_valid = 1'b0;
        end
      LCH_WAIT:
        if (cpl_valid)
        begin
          fin              = 1'b1;
          st_nxt.st        = LCH_IDLE;
          st_nxt.busy      = 1'b0;
        end
        else if (abort)
        begin
          st_nxt.st        = LCH_IDLE;
          st_nxt.busy      = 1'b0;
          st_nxt.cancel    = 1'b1;
        end
      default:
        st_nxt = '0;
    endcase
    if (!rst_n)
    begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    st_r <= st_nxt;
  end

  assign req       = st_r.req;
  assign req_valid = st_r.req_valid;
  assign cancel    = st_r.cancel;
  assign busy      = st_r.busy;

endmodule
`default_nettype wire

// *** logic/ptc_top.sv ***
`include "ptc_defines.svh"
`default_nettype none
module ptc_top
  import ptc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              pwr_on_rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  ptc_cfg_req_s      cfg_req,
  output logic                   cfg_req_valid,
  input  wire logic              cfg_req_ready,
  output logic                   cfg_cancel,
  input  wire logic              cpl_valid,
  input  wire ptc_cpl_s          cpl,
  output logic                   window4_enable
);

  // ============================================================
  // Elaboration checks
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_chk
    $error("ptc_top needs an address width of 8 to 32 bits.");
  end

  // ============================================================
  // Register addresses at the bus width
  localparam logic [ADDR_W-1:0] A_WIN4 = ADDR_W'(`PTC_OFF_WIN4);
  localparam logic [ADDR_W-1:0] A_CTL  = ADDR_W'(`PTC_OFF_CTL);
  localparam logic [ADDR_W-1:0] A_DATA = ADDR_W'(`PTC_OFF_DATA);
  localparam logic [ADDR_W-1:0] A_STS  = ADDR_W'(`PTC_OFF_STS);

  // ============================================================
  // State of the block in one record
  typedef struct packed {
    logic              awready;
    logic              aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic              wready;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              ar_have;
    logic [ADDR_W-1:0] araddr;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              win_en;
    logic [31:0]       ctl;
    logic [31:0]       data;
    logic              done;
    logic [2:0]        code;
    logic              aborted;
  } ptc_top_s;

  ptc_top_s     st_r;
  ptc_top_s     st_nxt;

  logic         wr_go;
  logic         rd_go;
  logic [31:0]  ctl_merged;
  logic [31:0]  data_merged;
  logic [31:0]  rd_word;
  logic         rd_err;
  logic         lch_go;
  logic         lch_abort;
  logic         lch_busy;
  logic         lch_fin;
  logic         core_rst_n;
  ptc_cfg_req_s lch_req;

  // A register access runs once both halves of a write, or the
  // read address, are held and the previous answer is gone.
  assign wr_go      = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
  assign rd_go      = st_r.ar_have & ~st_r.rvalid;
  assign core_rst_n = aresetn & pwr_on_rst_n;

  // ============================================================
  // Byte-lane merges for the control and data registers
  ptc_lane_merge #(
    .LANES    (4)
  ) u_ctl_merge (
    .old_word (st_r.ctl),
    .new_word (st_r.wdata),
    .strb     (st_r.wstrb),
    .wmask    (`PTC_CTL_WMASK),
    .merged   (ctl_merged)
  );

  ptc_lane_merge #(
    .LANES    (4)
  ) u_data_merge (
    .old_word (st_r.data),
    .new_word (st_r.wdata),
    .strb     (st_r.wstrb),
    .wmask    ({32{1'b1}}),
    .merged   (data_merged)
  );

  // ============================================================
  // Request built from the control fields and the data write
  always_comb
  begin
    lch_req.write = st_r.ctl[`PTC_CTL_RW_BIT];
    lch_req.kind  = st_r.ctl[`PTC_CTL_KIND_BIT];
    lch_req.be    = st_r.wstrb;
    lch_req.bus   = st_r.ctl[`PTC_CTL_BUS_HI:`PTC_CTL_BUS_LO];
    lch_req.slot  = st_r.ctl[`PTC_CTL_SLOT_HI:`PTC_CTL_SLOT_LO];
    lch_req.fn    = st_r.ctl[`PTC_CTL_FN_HI:`PTC_CTL_FN_LO];
    lch_req.upper = st_r.ctl[`PTC_CTL_UP_HI:`PTC_CTL_UP_LO];
    lch_req.dword = st_r.ctl[`PTC_CTL_DW_HI:`PTC_CTL_DW_LO];
    // A read carries the word too; the far side ignores it then.
    lch_req.data  = data_merged;
  end

  // ============================================================
  // Transaction launcher toward the far side
  ptc_launcher u_launcher (
    .aclk       (aclk),
    .rst_n      (core_rst_n),
    .launch     (lch_go),
    .launch_req (lch_req),
    .abort      (lch_abort),
    .req        (cfg_req),
    .req_valid  (cfg_req_valid),
    .req_ready  (cfg_req_ready),
    .cpl_valid  (cpl_valid),
    .cancel     (cfg_cancel),
    .busy       (lch_busy),
    .fin        (lch_fin)
  );

  // ============================================================
  // Read decode; unmapped addresses answer with a slave error.
  always_comb
  begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (st_r.araddr)
      A_WIN4:
      begin
        rd_word[`PTC_WIN4_SPACE_BIT] = `PTC_WIN4_SPACE_VAL;
        rd_word[`PTC_WIN4_TYPE_HI:`PTC_WIN4_TYPE_LO] =
          `PTC_WIN4_TYPE_VAL;
        rd_word[`PTC_WIN4_CACHE_BIT] = `PTC_WIN4_CACHE_VAL;
        rd_word[`PTC_WIN4_SIZE_HI:`PTC_WIN4_SIZE_LO] =
          `PTC_WIN4_SIZE_VAL;
        rd_word[`PTC_WIN4_EN_BIT] = st_r.win_en;
      end
      A_CTL:
        rd_word = st_r.ctl;
      A_DATA:
        rd_word = st_r.data;
      A_STS:
      begin
        rd_word[`PTC_STS_BUSY_BIT]  = lch_busy;
        rd_word[`PTC_STS_DONE_BIT]  = st_r.done;
        rd_word[`PTC_STS_CODE_HI:`PTC_STS_CODE_LO] = st_r.code;
        rd_word[`PTC_STS_ABORT_BIT] = st_r.aborted;
        rd_word[`PTC_STS_CAP_BIT]   = 1'b1;
      end
      default:
        rd_err = 1'b1;
    endcase
  end

  // ============================================================
  // Next-state logic for bus, registers and flags
  always_comb
  begin
    st_nxt    = st_r;
    lch_go    = 1'b0;
    lch_abort = 1'b0;

    // Address and data may arrive in either order.
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.ar_have = 1'b1;
      st_nxt.araddr  = s_axi_araddr;
    end

    // Answers stand until the master takes them.
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end

    // Read answer, one cycle after the address is taken.
    if (rd_go)
    begin
      st_nxt.ar_have = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = rd_word;
      st_nxt.rresp   = rd_err ? `PTC_RESP_SLVERR : `PTC_RESP_OKAY;
    end

    // Register write, one cycle after both halves are held.
    if (wr_go)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = `PTC_RESP_OKAY;
      case (st_r.awaddr)
        A_WIN4:
          // Every other bit of this register is fixed.
          if (st_r.wstrb[`PTC_WIN4_EN_LANE])
          begin
            st_nxt.win_en = st_r.wdata[`PTC_WIN4_EN_BIT];
          end
        A_CTL:
          st_nxt.ctl = ctl_merged;
        A_DATA:
          // A launch while busy is dropped so the transaction in
          // flight keeps its payload and its returned word.
          if (!lch_busy)
          begin
            lch_go         = 1'b1;
            st_nxt.done    = 1'b0;
            st_nxt.aborted = 1'b0;
            if (st_r.ctl[`PTC_CTL_RW_BIT])
            begin
              st_nxt.data = data_merged;
            end
          end
        A_STS:
          if (st_r.wstrb[0] && st_r.wdata[`PTC_STS_DONE_BIT])
          begin
            st_nxt.done = 1'b0;
            lch_abort   = lch_busy;
          end
        default:
          st_nxt.bresp = `PTC_RESP_SLVERR;
      endcase
    end

    // Completion is applied after the clear, so a completion in
    // the cycle of a write-one-to-clear still sets the flag.
    if (lch_fin)
    begin
      st_nxt.done    = 1'b1;
      st_nxt.code    = cpl.status;
      st_nxt.aborted = (cpl.status == `PTC_CPL_RA);
      if (!st_r.ctl[`PTC_CTL_RW_BIT])
      begin
        st_nxt.data = cpl.data;
      end
    end
    else if (lch_abort)
    begin
      // Abort by software is reported as a requester abort.
      st_nxt.code    = `PTC_CPL_RA;
      st_nxt.aborted = 1'b1;
    end

    // Ready only while nothing is held and no answer is pending.
    st_nxt.awready = ~st_nxt.aw_have & ~st_nxt.bvalid;
    st_nxt.wready  = ~st_nxt.w_have & ~st_nxt.bvalid;
    st_nxt.arready = ~st_nxt.ar_have & ~st_nxt.rvalid;

    // Hot reset keeps the sticky fields and the done flag; the bus
    // side, cycle kind, code and abort fields return to zero.
    if (!aresetn)
    begin
      st_nxt        = '0;
      st_nxt.win_en = st_r.win_en;
      st_nxt.ctl    = st_r.ctl & `PTC_CTL_STICKY;
      st_nxt.data   = st_r.data;
      st_nxt.done   = st_r.done;
    end
  end

  // ============================================================
  // State register; power-on reset clears everything.
  always_ff @(posedge aclk)
  begin
    if (!pwr_on_rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs straight from the state register
  assign s_axi_awready  = st_r.awready;
  assign s_axi_wready   = st_r.wready;
  assign s_axi_bvalid   = st_r.bvalid;
  assign s_axi_bresp    = st_r.bresp;
  assign s_axi_arready  = st_r.arready;
  assign s_axi_rvalid   = st_r.rvalid;
  assign s_axi_rdata    = st_r.rdata;
  assign s_axi_rresp    = st_r.rresp;
  // The window base logic elsewhere reads zero while this is low.
  assign window4_enable = st_r.win_en;

endmodule
`default_nettype wire

// *** verification/ptc_asserts.sv ***
`default_nettype none
// ============================================================
// Port checks of the punch-through generator
module ptc_asserts
  import ptc_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         pwr_on_rst_n,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic [3:0]   s_axi_wstrb,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire ptc_cfg_req_s cfg_req,
  input wire logic         cfg_req_valid,
  input wire logic         cfg_req_ready,
  input wire logic         cfg_cancel,
  input wire logic         window4_enable
);
  logic [3:0]  strb_r;
  logic [31:0] wdat_r;
  // Lanes that the last accepted write beat carried.
  wire logic [31:0] lane_m = {{8{strb_r[3]}}, {8{strb_r[2]}},
                              {8{strb_r[1]}}, {8{strb_r[0]}}};

  // Keep the last write beat, since a launch follows it a cycle later.
  always_ff @(posedge aclk)
  begin
    if (s_axi_wvalid && s_axi_wready)
    begin
      strb_r <= s_axi_wstrb;
      wdat_r <= s_axi_wdata;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !pwr_on_rst_n);

  // A launch shows up together with the write response.
  sequence s_launch;
    $rose(cfg_req_valid);
  endsequence
  sequence s_req_wait;
    cfg_req_valid && !cfg_req_ready;
  endsequence

  a_launch_resp: assert property (
    s_launch |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("launch without an OKAY write response");
  a_launch_lanes: assert property (
    s_launch |-> cfg_req.be == strb_r)
    else $error("request byte enables differ from the write strobes");
  a_write_payload: assert property (
    s_launch ##0 cfg_req.write |-> ((cfg_req.data ^ wdat_r) & lane_m) == 0)
    else $error("write payload differs from the written lanes");
  a_req_holds: assert property (
    s_req_wait |=> (cfg_req_valid && $stable(cfg_req)) || cfg_cancel)
    else $error("request dropped or changed before it was taken");
  a_req_taken: assert property (
    cfg_req_valid && cfg_req_ready |=> !cfg_req_valid)
    else $error("request still offered after it was taken");
  a_cancel_pulse: assert property (
    cfg_cancel |-> !cfg_req_valid ##1 !cfg_cancel)
    else $error("cancel is not a single cycle with the request withdrawn");
  a_win_by_write: assert property (
    $changed(window4_enable) |-> $rose(s_axi_bvalid))
    else $error("window enable moved without a register write");
  a_win_sticky: assert property (
    disable iff (!pwr_on_rst_n) !aresetn |=> $stable(window4_enable))
    else $error("window enable lost in hot reset");
endmodule

bind ptc_top ptc_asserts i_ptc_asserts (.aclk, .aresetn, .pwr_on_rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .cfg_req,
  .cfg_req_valid, .cfg_req_ready, .cfg_cancel, .window4_enable);
`default_nettype wire

// *** verification/ptc_far_model.sv ***
`default_nettype none
// ============================================================
// Far-side configuration target with a settable answer delay
module ptc_far_model
  import ptc_pkg::*;
(
  input  wire logic         aclk,
  input  wire ptc_cfg_req_s cfg_req,
  input  wire logic         cfg_req_valid,
  output logic              cfg_req_ready,
  input  wire logic         cfg_cancel,
  output logic              cpl_valid,
  output var  ptc_cpl_s     cpl,
  input  wire logic [5:0]   dly,
  input  wire logic [2:0]   sts,
  input  wire logic [31:0]  rdat,
  output var  ptc_cfg_req_s got,
  output int                n_got
);
  logic [5:0] cnt;
  logic       busy_m;
  wire logic  fin = busy_m && cnt == dly && !cfg_cancel;

  initial
  begin
    cfg_req_ready = 1'b0;
    cpl_valid = 1'b0;
    cpl = '0;
    cnt = 6'h0;
    busy_m = 1'b0;
    n_got = 0;
  end

  // Take a request dly cycles after it shows, answer dly cycles later.
  always @(posedge aclk)
  begin
    if (cfg_cancel || (!busy_m && !cfg_req_valid))
    begin
      busy_m <= 1'b0;
      cfg_req_ready <= 1'b0;
      cnt <= 6'h0;
    end
    else if (!busy_m && cfg_req_ready)
    begin
      got <= cfg_req;
      n_got <= n_got + 1;
      busy_m <= 1'b1;
      cfg_req_ready <= 1'b0;
      cnt <= 6'h0;
    end
    else if (!busy_m)
    begin
      cfg_req_ready <= cnt >= dly;
      cnt <= cnt + 6'h1;
    end
    else if (cnt == dly)
      busy_m <= 1'b0;
    else
      cnt <= cnt + 6'h1;
  end

  // Answer data toggles outside the pulse so a late sample cannot pass.
  always @(posedge aclk)
  begin
    cpl_valid <= fin;
    if (fin)
      cpl <= {sts, rdat};
    else
      cpl.data <= ~cpl.data;
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, pwr_on_rst_n, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cfg_req_valid, cfg_req_ready, cfg_cancel, cpl_valid;
  logic window4_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  dly;
  logic [2:0]  sts;
  ptc_pkg::ptc_cfg_req_s cfg_req, got;
  ptc_pkg::ptc_cpl_s     cpl;
  int miscompares = 0;
  int compares = 0;
  int n_got;

  ptc_top i_ptc_top (.aclk, .aresetn, .pwr_on_rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_req,
    .cfg_req_valid, .cfg_req_ready, .cfg_cancel, .cpl_valid, .cpl,
    .window4_enable);
  ptc_far_model i_ptc_far_model (.aclk, .cfg_req, .cfg_req_valid,
    .cfg_req_ready, .cfg_cancel, .cpl_valid, .cpl, .dly, .sts, .rdat,
    .got, .n_got);

  // ============================================================
  // Clock and helpers
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic close_out;
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [31:0] mrg(input logic [31:0] o, n,
                                     input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  // Status word: capable, aborted on requester abort, code and done.
  function automatic logic [31:0] stx(input logic [2:0] c, input logic dn);
    return 32'h8000_0000 | {26'h0, c == 3'h4, c, dn, 1'b0};
  endfunction

  // The master starts one edge late so a release and a new raise never
  // share a time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] re);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk(r, re);
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    logic [31:0] ctl, dat, nd, rv, s;
    logic [3:0]  st;
    logic [1:0]  r;
    int          nl, n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb, dly, sts, rdat} = 77'h0;
    seed = 32'hB084;
    aresetn = 1'b0;
    pwr_on_rst_n = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    pwr_on_rst_n <= 1'b1;
    rchk(8'h9C, 32'hC0, 2'h0);
    wr(8'h9C, 32'hFFFF_FFFF, 4'hF, r);
    rchk(8'h9C, 32'h8000_00C0, 2'h0);
    chk(window4_enable, 1'b1);
    wr(8'h40, 32'hFFFF_FFFF, 4'hF, r);
    chk(r, 2'h2);
    rchk(8'h40, 32'h0, 2'h2);
    dat = 32'h0;
    nl = 0;
    for (int i = 0; i < 15; i++)
    begin
      seed = xs(seed);
      ctl = seed & 32'hCFFF_FFFC;
      wr(8'hA0, seed, 4'hF, r);
      rd(8'hA0, s, r);
      chk(s[11:0], ctl[11:0]);
      chk(s[19:12], ctl[19:12]);
      chk({s[31:20], r}, {ctl[31:20], 2'h0});
      seed = xs(seed);
      rv = xs(seed);
      dly <= (i == 3) ? 6'd20 : {3'h0, seed[2:0]};
      sts <= 3'(i % 5);
      rdat <= rv;
      st = (seed[7:4] == 4'h0) ? 4'hF : seed[7:4];
      nd = mrg(dat, seed, st);
      wr(8'hA4, seed, st, r);
      nl++;
      if (i == 3) wr(8'hA4, ~seed, 4'hF, r);
      n = 0;
      do
      begin
        rd(8'hA8, s, r);
        n++;
      end while (s[0] !== 1'b0 && n < 80);
      chk(s, stx(3'(i % 5), 1'b1));
      chk(got[63:58], {ctl[31:30], st});
      chk(got[57:32], ctl[27:2]);
      if (ctl[31]) chk(got.data, nd);
      dat = ctl[31] ? nd : rv;
      rchk(8'hA4, dat, 2'h0);
    end
    chk(n_got, nl);
    wr(8'hA8, 32'h2, 4'h1, r);
    rchk(8'hA8, stx(3'h4, 1'b0), 2'h0);
    dly <= 6'd40;
    wr(8'hA4, 32'h1234_5678, 4'hF, r);
    // A write launch stores its word at once, even if aborted later.
    if (ctl[31]) dat = 32'h1234_5678;
    wr(8'hA8, 32'h2, 4'h1, r);
    rchk(8'hA8, stx(3'h4, 1'b0), 2'h0);
    chk(n_got, nl);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'hA0, ctl & 32'hBFFF_FFFC, 2'h0);
    rchk(8'hA4, dat, 2'h0);
    rchk(8'h9C, 32'h8000_00C0, 2'h0);
    wr(8'h9C, 32'h0, 4'h8, r);
    rchk(8'h9C, 32'h0000_00C0, 2'h0);
    chk(window4_enable, 1'b0);
    close_out();
  end

  // Watchdog well past the few hundred cycles the sequence needs.
  initial
  begin
    #(100 * 20000);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
